// ### rtl/pfc_pkg.sv
// Package: register map, field layout and reset values of the performance counter bank
package pfc_pkg;

   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_SAMPLE_TIMER = 8'h7C;
   localparam logic [7:0] OFS_SEC_IO_RD    = 8'h80;
   localparam logic [7:0] OFS_SEC_IO_WR    = 8'h84;
   localparam logic [7:0] OFS_SEC_MEM_RD   = 8'h88;
   localparam logic [7:0] OFS_SEC_MEM_WR   = 8'h8C;
   localparam logic [7:0] OFS_PRI_IO_RD    = 8'h90;
   localparam logic [7:0] OFS_PRI_IO_WR    = 8'h94;
   localparam logic [7:0] OFS_PRI_MEM_RD   = 8'h98;
   localparam logic [7:0] OFS_PRI_MEM_WR   = 8'h9C;
   localparam logic [7:0] OFS_SLOT_CAP     = 8'hB0;
   localparam logic [7:0] OFS_HS_CAP       = 8'hC0;

   // ----------------------------------------
   // Capability fields
   // ----------------------------------------
   localparam logic [7:0] SLOT_CAP_CODE    = 8'h04;
   localparam logic [7:0] HS_CAP_CODE      = 8'h06;
   localparam logic [7:0] HS_CAP_PTR       = 8'hC0;
   localparam logic [7:0] CHAIN_END        = 8'h00;
   localparam int         SLOT_NUM_LSB     = 16;
   localparam int         FIRST_CHASSIS_BIT = 21;
   localparam int         CHASSIS_LSB      = 24;

   // ----------------------------------------
   // Reset values and bus answers
   // ----------------------------------------
   localparam logic [31:0] CNT_RESET       = 32'h0000_0000;
   localparam logic [31:0] TIMER_RESET     = 32'h0000_0000;
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;
   localparam int          NUM_CNT         = 8;

   // Counter index: bit 2 = primary, bit 1 = memory, bit 0 = write
   typedef struct packed {
      logic [3:0] pri;   // io_rd, io_wr, mem_rd, mem_wr (bit 0 = io_rd)
      logic [3:0] sec;   // same order
   } pfc_events_t;

endpackage

// ### rtl/pfc_regs.sv
// Performance counter and capability register bank with an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
// How it works
// - Secondary I/O read counter at 80h
// - Secondary I/O write counter at 84h
// - Secondary memory read counter at 88h
// - Secondary memory write counter at 8Ch
// - Primary I/O read counter at 90h
// - Primary I/O write counter at 94h
// - Primary memory read counter at 98h
// - Primary memory write counter at 9Ch
// - Counters count events only during sampling window; register writes load them at any time
// - Nonzero timer write starts window; expiry clears counts
// - B0h low byte reads 04h
// - B0h pointer C0h if hot-swap enabled
// - Slot number and first-in-chassis writable
// - B0h bits 23:22 read zero
// - C0h low byte reads 06h
// - C0h pointer reads 00h
module pfc_regs (
   input  wire logic               clk_in,                 // 40 MHz bus clock
   input  wire logic               reset_n_in,             // Synchronous reset, active low
   input  wire logic               hot_swap_enable_input_in, // Hot-swap capability present
   input  wire pfc_pkg::pfc_events_t events_in,            // One-cycle successful completions
   input  wire logic               s_axi_awvalid_in,       // Write address valid
   input  wire logic [7:0]         s_axi_awaddr_in,        // Write byte address
   output logic                    s_axi_awready_out,      // Write address ready
   input  wire logic               s_axi_wvalid_in,        // Write data valid
   input  wire logic [31:0]        s_axi_wdata_in,         // Write data
   input  wire logic [3:0]         s_axi_wstrb_in,         // Write byte enables
   output logic                    s_axi_wready_out,       // Write data ready
   output logic                    s_axi_bvalid_out,       // Write response valid
   output logic [1:0]              s_axi_bresp_out,        // Write response
   input  wire logic               s_axi_bready_in,        // Write response ready
   input  wire logic               s_axi_arvalid_in,       // Read address valid
   input  wire logic [7:0]         s_axi_araddr_in,        // Read byte address
   output logic                    s_axi_arready_out,      // Read address ready
   output logic                    s_axi_rvalid_out,       // Read data valid
   output logic [31:0]             s_axi_rdata_out,        // Read data
   output logic [1:0]              s_axi_rresp_out,        // Read response
   input  wire logic               s_axi_rready_in,        // Read data ready
   output logic                    sampling_active_out     // Sampling window running
);

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   logic [31:0] cnt_r [pfc_pkg::NUM_CNT];
   logic [31:0] timer_r;
   logic [31:0] remain_r;
   logic        active_r;
   logic [4:0]  slot_num_r;
   logic        first_chassis_r;
   logic [7:0]  chassis_r;

   logic        aw_held_r;
   logic [7:0]  aw_addr_r;
   logic        w_held_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        wr_go;
   logic        wr_hit;
   logic [2:0]  wr_idx;
   logic [7:0]  rd_events;

   // Byte-enable merge of a write into an old word
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Counter slot for an offset in 80h..9Ch
   function automatic logic is_cnt(input logic [7:0] a);
      return (a >= pfc_pkg::OFS_SEC_IO_RD) && (a <= pfc_pkg::OFS_PRI_MEM_WR) && (a[1:0] == 2'h0);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      logic ok;
      ok = is_cnt(a);
      if (a == pfc_pkg::OFS_SAMPLE_TIMER) begin
         ok = 1'b1;
      end else if (a == pfc_pkg::OFS_SLOT_CAP) begin
         ok = 1'b1;
      end else if (a == pfc_pkg::OFS_HS_CAP) begin
         ok = 1'b1;
      end
      return ok;
   endfunction

   // ----------------------------------------
   // Write channel: address and data taken in either order
   // ----------------------------------------
   assign wr_go  = aw_held_r && w_held_r && !s_axi_bvalid_out;
   assign wr_hit = wr_go && is_mapped(aw_addr_r);
   assign wr_idx = aw_addr_r[4:2];
   assign rd_events = {events_in.pri, events_in.sec};

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         aw_held_r         <= 1'b0;
         aw_addr_r         <= 8'h00;
         s_axi_awready_out <= 1'b0;
      end else if (wr_go) begin
         aw_held_r         <= 1'b0;
         s_axi_awready_out <= 1'b0;
      end else if (!aw_held_r) begin
         s_axi_awready_out <= !s_axi_awready_out ? 1'b1 : !s_axi_awvalid_in;
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_held_r         <= 1'b1;
            aw_addr_r         <= s_axi_awaddr_in;
            s_axi_awready_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         w_held_r         <= 1'b0;
         w_data_r         <= 32'h0000_0000;
         w_strb_r         <= 4'h0;
         s_axi_wready_out <= 1'b0;
      end else if (wr_go) begin
         w_held_r         <= 1'b0;
         s_axi_wready_out <= 1'b0;
      end else if (!w_held_r) begin
         s_axi_wready_out <= 1'b1;
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_held_r         <= 1'b1;
            w_data_r         <= s_axi_wdata_in;
            w_strb_r         <= s_axi_wstrb_in;
            s_axi_wready_out <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out  <= pfc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out  <= wr_hit ? pfc_pkg::RESP_OKAY : pfc_pkg::RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // Sampling timer
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         timer_r  <= pfc_pkg::TIMER_RESET;
         remain_r <= pfc_pkg::TIMER_RESET;
         active_r <= 1'b0;
      end else if (wr_hit && aw_addr_r == pfc_pkg::OFS_SAMPLE_TIMER) begin
         timer_r  <= merge(timer_r, w_data_r, w_strb_r);
         remain_r <= merge(timer_r, w_data_r, w_strb_r);
         active_r <= (merge(timer_r, w_data_r, w_strb_r) != 32'h0000_0000);
      end else if (active_r) begin
         remain_r <= remain_r - 32'h0000_0001;
         if (remain_r == 32'h0000_0001) begin
            active_r <= 1'b0;
         end
      end
   end

   // Pin copy lags the window by one cycle; it is a status view only
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         sampling_active_out <= 1'b0;
      end else begin
         sampling_active_out <= active_r;
      end
   end

   // ----------------------------------------
   // Transaction counters
   // ----------------------------------------
   // Expiry clears the counts in the cycle the window closes, so software
   // must read them while the window still runs.
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < pfc_pkg::NUM_CNT; i++) begin
            cnt_r[i] <= pfc_pkg::CNT_RESET;
         end
      end else begin
         for (int i = 0; i < pfc_pkg::NUM_CNT; i++) begin
            if (wr_hit && is_cnt(aw_addr_r) && wr_idx == 3'(i)) begin
               cnt_r[i] <= merge(cnt_r[i], w_data_r, w_strb_r);
            end else if (active_r && remain_r == 32'h0000_0001) begin
               cnt_r[i] <= pfc_pkg::CNT_RESET;
            end else if (active_r && rd_events[i]) begin
               cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
            end
         end
      end
   end

   // ----------------------------------------
   // Slot identification fields
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         slot_num_r      <= 5'h00;
         first_chassis_r <= 1'b0;
         chassis_r       <= 8'h00;
      end else if (wr_hit && aw_addr_r == pfc_pkg::OFS_SLOT_CAP) begin
         if (w_strb_r[2]) begin
            slot_num_r      <= w_data_r[pfc_pkg::SLOT_NUM_LSB +: 5];
            first_chassis_r <= w_data_r[pfc_pkg::FIRST_CHASSIS_BIT];
         end
         if (w_strb_r[3]) begin
            chassis_r <= w_data_r[pfc_pkg::CHASSIS_LSB +: 8];
         end
      end
   end

   // ----------------------------------------
   // Read channel
   // ----------------------------------------
   function automatic logic [31:0] rd_word(input logic [7:0] a);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (is_cnt(a)) begin
         d = cnt_r[a[4:2]];
      end else if (a == pfc_pkg::OFS_SAMPLE_TIMER) begin
         d = timer_r;
      end else if (a == pfc_pkg::OFS_SLOT_CAP) begin
         d = {chassis_r, 2'b00, first_chassis_r, slot_num_r,
              hot_swap_enable_input_in ? pfc_pkg::HS_CAP_PTR : pfc_pkg::CHAIN_END,
              pfc_pkg::SLOT_CAP_CODE};
      end else if (a == pfc_pkg::OFS_HS_CAP) begin
         d = {16'h0000, pfc_pkg::CHAIN_END, pfc_pkg::HS_CAP_CODE};
      end
      return d;
   endfunction

   always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b0;
         s_axi_rdata_out   <= 32'h0000_0000;
         s_axi_rresp_out   <= pfc_pkg::RESP_OKAY;
      end else if (s_axi_rvalid_out) begin
         s_axi_arready_out <= 1'b0;
         if (s_axi_rready_in) begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
         end
      end else if (s_axi_arvalid_in && s_axi_arready_out) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out  <= 1'b1;
         s_axi_rdata_out   <= rd_word(s_axi_araddr_in);
         s_axi_rresp_out   <= is_mapped(s_axi_araddr_in) ? pfc_pkg::RESP_OKAY
                                                         : pfc_pkg::RESP_SLVERR;
      end else begin
         s_axi_arready_out <= 1'b1;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_HOLD_OUTSIDE_WINDOW: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (!active_r && !wr_hit) |=> (cnt_r[0] == $past(cnt_r[0])))
      else $error("counter moved outside sampling window");
   AST_SEC_IO_RD_INC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (active_r && remain_r != 32'h0000_0001 && events_in.sec[0] && !wr_hit)
      |=> cnt_r[0] == $past(cnt_r[0]) + 32'h0000_0001)
      else $error("secondary io read count did not step");
   AST_PRI_MEM_WR_INC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (active_r && remain_r != 32'h0000_0001 && events_in.pri[3] && !wr_hit)
      |=> cnt_r[7] == $past(cnt_r[7]) + 32'h0000_0001)
      else $error("primary memory write count did not step");
   AST_EXPIRY_CLEARS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (active_r && remain_r == 32'h0000_0001 && !wr_hit) |=> (!active_r && cnt_r[3] == 32'h0))
      else $error("expiry did not end window and clear");
   AST_TIMER_START: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (wr_hit && aw_addr_r == pfc_pkg::OFS_SAMPLE_TIMER && w_strb_r == 4'hF && w_data_r != 32'h0)
      |=> active_r ##1 sampling_active_out)
      else $error("timer write did not open window");
   AST_SW_LOAD: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (wr_hit && aw_addr_r == pfc_pkg::OFS_PRI_IO_RD && w_strb_r == 4'hF)
      |=> cnt_r[4] == $past(w_data_r))
      else $error("counter write not loaded");
   AST_SLOT_ID: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (s_axi_rvalid_out && !$past(s_axi_rvalid_out)
       && $past(s_axi_araddr_in) == pfc_pkg::OFS_SLOT_CAP)
      |-> (s_axi_rdata_out[7:0] == 8'h04 && s_axi_rdata_out[23:22] == 2'b00))
      else $error("slot capability word wrong");
   AST_HS_ID: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (s_axi_rvalid_out && !$past(s_axi_rvalid_out)
       && $past(s_axi_araddr_in) == pfc_pkg::OFS_HS_CAP)
      |-> s_axi_rdata_out[15:0] == 16'h0006)
      else $error("hot-swap capability word wrong");
   AST_BRESP_FOLLOWS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wr_go |=> s_axi_bvalid_out)
      else $error("write response missing");
   AST_SEC_IO_WR_INC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (active_r && remain_r != 32'h0000_0001 && events_in.sec[1] && !wr_hit)
      |=> cnt_r[1] == $past(cnt_r[1]) + 32'h0000_0001)
      else $error("secondary io write count did not step");
   AST_SEC_MEM_RD_INC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (active_r && remain_r != 32'h0000_0001 && events_in.sec[2] && !wr_hit)
      |=> cnt_r[2] == $past(cnt_r[2]) + 32'h0000_0001)
      else $error("secondary memory read count did not step");
   AST_SEC_MEM_WR_INC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (active_r && remain_r != 32'h0000_0001 && events_in.sec[3] && !wr_hit)
      |=> cnt_r[3] == $past(cnt_r[3]) + 32'h0000_0001)
      else $error("secondary memory write count did not step");
   AST_PRI_IO_RD_INC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (active_r && remain_r != 32'h0000_0001 && events_in.pri[0] && !wr_hit)
      |=> cnt_r[4] == $past(cnt_r[4]) + 32'h0000_0001)
      else $error("primary io read count did not step");
   AST_PRI_IO_WR_INC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (active_r && remain_r != 32'h0000_0001 && events_in.pri[1] && !wr_hit)
      |=> cnt_r[5] == $past(cnt_r[5]) + 32'h0000_0001)
      else $error("primary io write count did not step");
   AST_PRI_MEM_RD_INC: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (active_r && remain_r != 32'h0000_0001 && events_in.pri[2] && !wr_hit)
      |=> cnt_r[6] == $past(cnt_r[6]) + 32'h0000_0001)
      else $error("primary memory read count did not step");
   AST_HOLD_PRI: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (!active_r && !wr_hit) |=> (cnt_r[7] == $past(cnt_r[7])))
      else $error("primary counter moved outside sampling window");
   // No disable here: the check is about what reset itself leaves behind
   AST_RESET_CLEARS: assert property (@(posedge clk_in)
      !reset_n_in |=> ((cnt_r[0] | cnt_r[1] | cnt_r[2] | cnt_r[3] | cnt_r[4] | cnt_r[5]
                        | cnt_r[6] | cnt_r[7]) == 32'h0000_0000 && !active_r))
      else $error("reset did not clear counters");
   AST_SLOT_PTR: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (s_axi_rvalid_out && !$past(s_axi_rvalid_out)
       && $past(s_axi_araddr_in) == pfc_pkg::OFS_SLOT_CAP)
      |-> s_axi_rdata_out[15:8] == ($past(hot_swap_enable_input_in) ? 8'hC0 : 8'h00))
      else $error("slot capability pointer wrong");
   AST_SLOT_FIELDS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (wr_hit && aw_addr_r == pfc_pkg::OFS_SLOT_CAP && w_strb_r[2])
      |=> {first_chassis_r, slot_num_r} == $past(w_data_r[21:16]))
      else $error("slot number fields not loaded");
   AST_HS_UPPER: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (s_axi_rvalid_out && !$past(s_axi_rvalid_out)
       && $past(s_axi_araddr_in) == pfc_pkg::OFS_HS_CAP)
      |-> s_axi_rdata_out[31:16] == 16'h0000)
      else $error("hot-swap capability upper half not zero");

   // Bus channel discipline
   AST_RD_ANSWER: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (s_axi_arvalid_in && s_axi_arready_out) |=> s_axi_rvalid_out)
      else $error("read answer missing");
   AST_AW_BLOCKED: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      aw_held_r |-> !s_axi_awready_out)
      else $error("write address taken while one is held");
   AST_W_BLOCKED: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      w_held_r |-> !s_axi_wready_out)
      else $error("write data taken while one is held");
   AST_BVALID_HOLDS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (s_axi_bvalid_out && !s_axi_bready_in) |=> (s_axi_bvalid_out && $stable(s_axi_bresp_out)))
      else $error("write response dropped early");
   AST_RVALID_HOLDS: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      (s_axi_rvalid_out && !s_axi_rready_in) |=> (s_axi_rvalid_out && $stable(s_axi_rdata_out)))
      else $error("read answer dropped early");

   COV_WINDOW: cover property (@(posedge clk_in) disable iff (!reset_n_in) $fell(active_r));
   COV_COUNT: cover property (@(posedge clk_in) disable iff (!reset_n_in)
      active_r && events_in.pri[0]);
   COV_BAD_ADDR: cover property (@(posedge clk_in) disable iff (!reset_n_in)
      s_axi_rvalid_out && s_axi_rresp_out == pfc_pkg::RESP_SLVERR);
   COV_SW_LOAD: cover property (@(posedge clk_in) disable iff (!reset_n_in)
      wr_hit && is_cnt(aw_addr_r));
   COV_PTR_END: cover property (@(posedge clk_in) disable iff (!reset_n_in)
      s_axi_rvalid_out && !hot_swap_enable_input_in);

endmodule

// ### verification/tb_top.sv
// Self-checking testbench for the performance counter and capability register bank
`timescale 1ns/100ps
module tb_top;
   // ----------------------------------------
   // Signals and design instance
   // ----------------------------------------
   logic                clk_in;
   logic                reset_n_in;
   logic                hot_swap_enable_input;
   pfc_pkg::pfc_events_t ev;
   logic                awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]          awaddr, araddr;
   logic [31:0]         wdata;
   logic [3:0]          wstrb;
   logic                awready, wready, bvalid, arready, rvalid, active;
   logic [1:0]          bresp, rresp;
   logic [31:0]         rdata;
   int                  miscompares;
   int                  tests_run;

   pfc_regs pfc_regs_inst (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .hot_swap_enable_input_in(hot_swap_enable_input),
      .events_in(ev), .s_axi_awvalid_in(awvalid), .s_axi_awaddr_in(awaddr),
      .s_axi_awready_out(awready), .s_axi_wvalid_in(wvalid), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_wready_out(wready), .s_axi_bvalid_out(bvalid),
      .s_axi_bresp_out(bresp), .s_axi_bready_in(bready), .s_axi_arvalid_in(arvalid),
      .s_axi_araddr_in(araddr), .s_axi_arready_out(arready), .s_axi_rvalid_out(rvalid),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rready_in(rready),
      .sampling_active_out(active));

   initial clk_in = 1'b0;
   always #12.5 clk_in = ~clk_in;

   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task print_verdict;
      if (miscompares == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task guard(input int n);
      if (n > 200) begin
         miscompares++;
         $display("Error at %0t: bus wait ran out", $time);
         print_verdict;
      end
   endtask

   // Handshakes are judged at the falling edge: outputs are registered, so the
   // value seen there is the one the next rising edge samples.
   task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
               input logic [1:0] er);
      logic aw_hs, w_hs, aw_done, w_done, b_hs;
      logic [1:0] r;
      int n;
      aw_done = 1'b0;
      w_done = 1'b0;
      b_hs = 1'b0;
      n = 0;
      @(posedge clk_in);
      awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; wstrb <= s; bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(negedge clk_in);
         aw_hs = awvalid && awready;
         w_hs = wvalid && wready;
         @(posedge clk_in);
         if (aw_hs) begin awvalid <= 1'b0; aw_done = 1'b1; end
         if (w_hs) begin wvalid <= 1'b0; w_done = 1'b1; end
         guard(n++);
      end
      while (!b_hs) begin
         @(negedge clk_in);
         b_hs = bvalid;
         r = bresp;
         @(posedge clk_in);
         guard(n++);
      end
      bready <= 1'b0;
      check({30'h0, r}, {30'h0, er});
   endtask

   task axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic ar_hs, r_hs;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      ar_hs = 1'b0;
      r_hs = 1'b0;
      n = 0;
      @(posedge clk_in);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      while (!ar_hs) begin
         @(negedge clk_in);
         ar_hs = arready;
         @(posedge clk_in);
         guard(n++);
      end
      arvalid <= 1'b0;
      while (!r_hs) begin
         @(negedge clk_in);
         r_hs = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk_in);
         guard(n++);
      end
      rready <= 1'b0;
      check(d, exp);
      check({30'h0, r}, {30'h0, er});
   endtask

   task do_reset;
      reset_n_in <= 1'b0;
      repeat (20) @(posedge clk_in);
      reset_n_in <= 1'b1;
   endtask

   // Counter i is expected to read base + step * i
   task rd_counters(input logic [31:0] base, input logic [31:0] step);
      for (int i = 0; i < 8; i++) begin
         axi_rd(8'(pfc_pkg::OFS_SEC_IO_RD + 4 * i), base + step * 32'(i), pfc_pkg::RESP_OKAY);
      end
   endtask

   task pulse_events;
      // Runs of back-to-back pulses, i+1 on event i, then one cycle with all set
      for (int i = 0; i < 8; i++) begin
         for (int j = 0; j <= i; j++) begin
            @(posedge clk_in);
            ev <= pfc_pkg::pfc_events_t'(8'h01 << i);
         end
         @(posedge clk_in);
         ev <= pfc_pkg::pfc_events_t'(8'h00);
      end
      @(posedge clk_in);
      ev <= pfc_pkg::pfc_events_t'(8'hFF);
      @(posedge clk_in);
      ev <= pfc_pkg::pfc_events_t'(8'h00);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      int n;
      miscompares = 0; tests_run = 0;
      reset_n_in = 1'b0; hot_swap_enable_input = 1'b1; ev = pfc_pkg::pfc_events_t'(8'h00);
      awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
      awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'h0;
      do_reset;
      rd_counters(32'h0000_0000, 32'h0000_0000);
      axi_rd(pfc_pkg::OFS_SLOT_CAP, 32'h0000_C004, pfc_pkg::RESP_OKAY);
      axi_rd(pfc_pkg::OFS_HS_CAP, 32'h0000_0006, pfc_pkg::RESP_OKAY);
      @(posedge clk_in);
      hot_swap_enable_input <= 1'b0;
      axi_rd(pfc_pkg::OFS_SLOT_CAP, 32'h0000_0004, pfc_pkg::RESP_OKAY);
      // Events with the window closed must leave the counters alone
      pulse_events;
      rd_counters(32'h0000_0000, 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
         axi_wr(8'(pfc_pkg::OFS_SEC_IO_RD + 4 * i), 32'hFFFF_FF00 + 32'(i), 4'hF,
                pfc_pkg::RESP_OKAY);
      end
      rd_counters(32'hFFFF_FF00, 32'h0000_0001);
      axi_wr(pfc_pkg::OFS_SAMPLE_TIMER, 32'h0000_012C, 4'hF, pfc_pkg::RESP_OKAY);
      n = 0;
      while (active !== 1'b1) begin
         @(posedge clk_in);
         guard(n++);
      end
      // Counter i took i + 2 events on top of its preset value
      pulse_events;
      rd_counters(32'hFFFF_FF02, 32'h0000_0002);
      axi_rd(pfc_pkg::OFS_SAMPLE_TIMER, 32'h0000_012C, pfc_pkg::RESP_OKAY);
      check({31'h0, active}, 32'h0000_0001);
      n = 0;
      while (active !== 1'b0) begin
         @(posedge clk_in);
         guard(n / 2);
         n++;
      end
      rd_counters(32'h0000_0000, 32'h0000_0000);
      // A zero timer value must not open a window
      axi_wr(pfc_pkg::OFS_SAMPLE_TIMER, 32'h0000_0000, 4'hF, pfc_pkg::RESP_OKAY);
      repeat (2) @(posedge clk_in);
      check({31'h0, active}, 32'h0000_0000);
      pulse_events;
      rd_counters(32'h0000_0000, 32'h0000_0000);
      // Slot register: writable fields, read-only bits and byte strobes
      axi_wr(pfc_pkg::OFS_SLOT_CAP, 32'hFFFF_FFFF, 4'hF, pfc_pkg::RESP_OKAY);
      axi_rd(pfc_pkg::OFS_SLOT_CAP, 32'hFF3F_0004, pfc_pkg::RESP_OKAY);
      axi_wr(pfc_pkg::OFS_SLOT_CAP, 32'h0000_0000, 4'h4, pfc_pkg::RESP_OKAY);
      axi_rd(pfc_pkg::OFS_SLOT_CAP, 32'hFF00_0004, pfc_pkg::RESP_OKAY);
      axi_wr(pfc_pkg::OFS_HS_CAP, 32'hFFFF_FFFF, 4'hF, pfc_pkg::RESP_OKAY);
      axi_rd(pfc_pkg::OFS_HS_CAP, 32'h0000_0006, pfc_pkg::RESP_OKAY);
      // Unmapped place is refused on both paths
      axi_wr(8'hA0, 32'h1234_5678, 4'hF, pfc_pkg::RESP_SLVERR);
      axi_rd(8'hA0, 32'h0000_0000, pfc_pkg::RESP_SLVERR);
      // A second reset mid-run returns the writable fields to zero
      @(posedge clk_in);
      hot_swap_enable_input <= 1'b1;
      do_reset;
      axi_rd(pfc_pkg::OFS_SLOT_CAP, 32'h0000_C004, pfc_pkg::RESP_OKAY);
      print_verdict;
   end
endmodule
